// ===== logic/smc_core.v
// serial memory slave: opcode decode, status, array access, pause
// How it works
// R1: eight-bit opcode after select goes low; six opcodes recognised
// R2: select rising before eight opcode bits executes nothing
// R3: host sends only the six defined opcodes
// R4: set-latch opcode sets write latch; writes need it set
// R5: clear-latch opcode clears write latch; writes then have no effect
// R6: status read drives status byte on falling edges, input ignored
// R7: continued clocking repeats the status byte
// R8: status write loads bits 7..2; latch bit value discarded
// R9: status bit 0 reads zero; its written value discarded
// R10: host holds write-guard pin steady through a status write
// R11: memory read takes 16-bit address, top three bits ignored
// R12: each further eight clocks reads the next address
// R13: address wraps from top of array to zero
// R14: memory write takes address, stores each complete byte
// R15: further complete bytes go to incremented addresses
// R16: block guard bits select protected upper range
// R17: latch clear blocks all writes; guarded range never written
// R18: latch set: status write blocked only if locked and pin low
// R19: pause suspends command, ignores clock and data, floats output
// R20: pause start and end follow the clock level
// R21: deselect during pause aborts and resets the interface
// R22: input sampled on rising, output changed on falling clock edge
// R23: deselected device floats output and ignores other inputs
// R24: latch clears at reset and after clear, status and memory writes
// R25: status: lock bit 7, spare 6..4, guard 3..2, latch bit 1
// R26: unknown opcode: ignore input, float output until deselect
`timescale 1ns/100ps
`include "smc_regs.vh"

module smc_core
(
    // clock and reset
    input  wire                   clk_sys_i,
    input  wire                   reset_i,
    // serial pins, asynchronous to clk_sys_i
    input  wire                   sel_n_i,
    input  wire                   sclk_i,
    input  wire                   sdi_i,
    input  wire                   pause_n_i,
    input  wire                   wr_guard_n_i,
    output wire                   sdo_o,
    output wire                   sdo_oe_n_o,
    // commit stream of accepted write bytes
    output wire                   commit_valid_o,
    input  wire                   commit_ready_i,
    output wire [`SMC_AW-1:0]     commit_addr_o,
    output wire [7:0]             commit_data_o,
    // observation
    output wire [7:0]             status_o,
    output wire                   paused_o,
    output wire                   overrun_o
);

    localparam PH_OPC  = 3'd0;
    localparam PH_ADDR = 3'd1;
    localparam PH_DATA = 3'd2;
    localparam PH_TX   = 3'd3;
    localparam PH_IGN  = 3'd4;

    localparam CM_NONE = 2'd0;
    localparam CM_SWR  = 2'd1;
    localparam CM_MRD  = 2'd2;
    localparam CM_MWR  = 2'd3;

    // guarded range test for a given address and guard setting
    // R16: guard range select
    function smc_guarded;
        input [`SMC_AW-1:0] addr;
        input [1:0]         guard;
        begin
            case (guard)
                2'b00:   smc_guarded = 1'b0;
                2'b01:   smc_guarded = (addr >= `SMC_GUARD_QTR);
                2'b10:   smc_guarded = (addr >= `SMC_GUARD_HALF);
                default: smc_guarded = 1'b1;
            endcase
        end
    endfunction

    // pin synchronisers; stage one is read only by stage two
    reg  [4:0]            meta_r;
    reg  [4:0]            sync_r;
    reg                   sclk_d_r;
    wire                  sel_n_s;
    wire                  sclk_s;
    wire                  sdi_s;
    wire                  pause_n_s;
    wire                  guard_n_s;

    always @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            meta_r   <= 5'h1f;
            sync_r   <= 5'h1f;
            sclk_d_r <= 1'b1;
        end
        else
        begin
            meta_r   <= {sel_n_i, sclk_i, sdi_i, pause_n_i, wr_guard_n_i};
            sync_r   <= meta_r;
            sclk_d_r <= sync_r[3];
        end
    end

    assign sel_n_s   = sync_r[4];
    assign sclk_s    = sync_r[3];
    assign sdi_s     = sync_r[2];
    assign pause_n_s = sync_r[1];
    assign guard_n_s = sync_r[0];

    // state
    reg  [2:0]            phase_r;
    reg  [1:0]            cmd_r;
    reg  [2:0]            bit_cnt_r;
    reg  [3:0]            addr_cnt_r;
    reg  [7:0]            shift_r;
    reg  [`SMC_AW-1:0]    addr_r;
    reg                   latch_r;
    reg  [5:0]            stat_r;
    reg                   pause_r;
    reg                   sdo_r;
    reg                   overrun_r;
    reg  [7:0]            rd_byte_r;
    reg  [7:0]            array_r [0:`SMC_DEPTH-1];

    wire                  sclk_rise;
    wire                  sclk_fall;
    wire                  live;
    wire [7:0]            shift_nxt;
    wire [7:0]            status_byte;
    wire [7:0]            tx_byte;
    wire                  stat_wr_ok;
    wire                  mem_wr_ok;
    wire                  buf_in_ready;
    wire                  buf_out_valid;
    wire [`SMC_BUF_W-1:0] buf_out_data;
    reg                   push_r;
    reg  [`SMC_BUF_W-1:0] push_data_r;

    assign sclk_rise = sclk_s & ~sclk_d_r;
    assign sclk_fall = ~sclk_s & sclk_d_r;
    // R19: no clocking while paused
    assign live      = ~sel_n_s & ~pause_r;
    assign shift_nxt = {shift_r[6:0], sdi_s};

    // R25: status layout
    // R9: bit 0 fixed low
    assign status_byte = {stat_r, latch_r, 1'b0};
    assign tx_byte     = (cmd_r == CM_NONE) ? status_byte : rd_byte_r;

    // R18: status write allowed unless locked with pin low
    assign stat_wr_ok = latch_r &
                        ~(stat_r[`SMC_ST_LOCK-2] & ~guard_n_s);
    // R17: latch needed, guarded range never written
    assign mem_wr_ok  = latch_r &
                        ~smc_guarded(addr_r,
                                     stat_r[`SMC_ST_GUARD_HI-2:
                                            `SMC_ST_GUARD_LO-2]);

    // R20: pause starts or ends only while the clock is low; deselect clears it at once
    always @(posedge clk_sys_i)
    begin
        if (reset_i | sel_n_s)
        begin
            pause_r <= 1'b0;
        end
        else if (~sclk_s)
        begin
            pause_r <= ~pause_n_s;
        end
    end

    // registered array read; settles well before the next falling edge
    always @(posedge clk_sys_i)
    begin
        rd_byte_r <= array_r[addr_r];
    end

    // array write happens when the commit stream drains a word
    always @(posedge clk_sys_i)
    begin
        if (buf_out_valid & commit_ready_i)
        begin
            array_r[buf_out_data[`SMC_BUF_W-1:8]] <= buf_out_data[7:0];
        end
    end

    always @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            phase_r     <= PH_OPC;
            cmd_r       <= CM_NONE;
            bit_cnt_r   <= 3'd0;
            addr_cnt_r  <= 4'd0;
            shift_r     <= 8'h00;
            addr_r      <= {`SMC_AW{1'b0}};
            // R24: latch clear at reset
            latch_r     <= 1'b0;
            stat_r      <= `SMC_ST_RESET;
            sdo_r       <= 1'b0;
            overrun_r   <= 1'b0;
            push_r      <= 1'b0;
            push_data_r <= {`SMC_BUF_W{1'b0}};
        end
        else if (sel_n_s)
        begin
            // R21: deselect, even while paused, returns to idle
            // R2: partial opcode leaves nothing behind
            phase_r    <= PH_OPC;
            cmd_r      <= CM_NONE;
            bit_cnt_r  <= 3'd0;
            addr_cnt_r <= 4'd0;
            overrun_r  <= 1'b0;
            push_r     <= 1'b0;
            // R24: latch clears when a write command completes
            if ((cmd_r == CM_SWR) | (cmd_r == CM_MWR))
            begin
                latch_r <= 1'b0;
            end
        end
        else
        begin
            push_r <= 1'b0;
            if (push_r & ~buf_in_ready)
            begin
                overrun_r <= 1'b1;
            end
            // R22: sample on rising edge
            if (live & sclk_rise)
            begin
                shift_r   <= shift_nxt;
                bit_cnt_r <= bit_cnt_r + 3'd1;
                case (phase_r)
                    PH_OPC:
                    begin
                        // R1: decode after eighth bit
                        if (bit_cnt_r == 3'd7)
                        begin
                            case (shift_nxt)
                                // R4: set latch
                                `SMC_OP_SET_LATCH:
                                begin
                                    latch_r <= 1'b1;
                                    phase_r <= PH_IGN;
                                end
                                // R5: clear latch
                                `SMC_OP_CLR_LATCH:
                                begin
                                    latch_r <= 1'b0;
                                    phase_r <= PH_IGN;
                                end
                                `SMC_OP_STAT_READ:
                                begin
                                    phase_r <= PH_TX;
                                end
                                `SMC_OP_STAT_WRITE:
                                begin
                                    cmd_r   <= CM_SWR;
                                    phase_r <= PH_DATA;
                                end
                                `SMC_OP_MEM_READ:
                                begin
                                    cmd_r   <= CM_MRD;
                                    phase_r <= PH_ADDR;
                                end
                                `SMC_OP_MEM_WRITE:
                                begin
                                    cmd_r   <= CM_MWR;
                                    phase_r <= PH_ADDR;
                                end
                                // R26: unknown opcode is ignored
                                default:
                                begin
                                    phase_r <= PH_IGN;
                                end
                            endcase
                        end
                    end
                    PH_ADDR:
                    begin
                        // R11: only the low address bits are kept
                        addr_r     <= {addr_r[`SMC_AW-2:0], sdi_s};
                        addr_cnt_r <= addr_cnt_r + 4'd1;
                        bit_cnt_r  <= 3'd0;
                        if (addr_cnt_r == `SMC_ADDR_BITS)
                        begin
                            phase_r <= (cmd_r == CM_MRD) ? PH_TX : PH_DATA;
                        end
                    end
                    PH_DATA:
                    begin
                        if (bit_cnt_r == 3'd7)
                        begin
                            if (cmd_r == CM_SWR)
                            begin
                                // R8: latch bit of the data is dropped
                                if (stat_wr_ok)
                                begin
                                    stat_r <= shift_nxt[7:2];
                                end
                                phase_r <= PH_IGN;
                            end
                            else
                            begin
                                // R14: store each complete byte
                                if (mem_wr_ok)
                                begin
                                    push_r      <= 1'b1;
                                    push_data_r <= {addr_r, shift_nxt};
                                end
                                // R15: next byte, next address
                                // R13: wraps by width
                                addr_r <= addr_r + 1'b1;
                            end
                        end
                    end
                    PH_TX:
                    begin
                        // R12: advance after each output byte
                        // R13: wraps by width
                        if ((bit_cnt_r == 3'd7) & (cmd_r == CM_MRD))
                        begin
                            addr_r <= addr_r + 1'b1;
                        end
                    end
                    default:
                    begin
                        phase_r <= PH_IGN;
                    end
                endcase
            end
            // R6: output changes on the falling edge
            // R7: bit count wraps, so the status byte repeats
            if (live & sclk_fall & (phase_r == PH_TX))
            begin
                sdo_r <= tx_byte[~bit_cnt_r];
            end
        end
    end

    smc_buf u_buf
    (
        .clk_sys_i   (clk_sys_i),
        .reset_i     (reset_i),
        .in_valid_i  (push_r),
        .in_ready_o  (buf_in_ready),
        .in_data_i   (push_data_r),
        .out_valid_o (buf_out_valid),
        .out_ready_i (commit_ready_i),
        .out_data_o  (buf_out_data)
    );

    // R23: float when deselected
    // R19: float while paused
    assign sdo_o          = sdo_r;
    assign sdo_oe_n_o     = ~(live & (phase_r == PH_TX));
    assign commit_valid_o = buf_out_valid;
    assign commit_addr_o  = buf_out_data[`SMC_BUF_W-1:8];
    assign commit_data_o  = buf_out_data[7:0];
    assign status_o       = status_byte;
    assign paused_o       = pause_r;
    assign overrun_o      = overrun_r;

endmodule

// ===== shared/smc_regs.vh
// constants for the serial memory command logic
`ifndef SMC_REGS_VH
`define SMC_REGS_VH

// opcodes
`define SMC_OP_SET_LATCH    8'h06
`define SMC_OP_CLR_LATCH    8'h04
`define SMC_OP_STAT_READ    8'h05
`define SMC_OP_STAT_WRITE   8'h01
`define SMC_OP_MEM_READ     8'h03
`define SMC_OP_MEM_WRITE    8'h02

// status byte field positions
`define SMC_ST_LOCK         7
`define SMC_ST_SPARE_HI     6
`define SMC_ST_SPARE_LO     4
`define SMC_ST_GUARD_HI     3
`define SMC_ST_GUARD_LO     2
`define SMC_ST_LATCH        1
`define SMC_ST_ZERO         0

// reset value of the stored status bits 7..2
`define SMC_ST_RESET        6'h00

// array geometry
`define SMC_AW              13
`define SMC_DEPTH           8192
`define SMC_ADDR_BITS       4'hf

// guarded range lower bounds for block guard 01 and 10
`define SMC_GUARD_QTR       13'h1800
`define SMC_GUARD_HALF      13'h1000

// commit buffer word: address and data
`define SMC_BUF_W           21

`endif

// ===== logic/smc_buf.v
// two-entry buffer between received write bytes and the array port
`timescale 1ns/100ps
`include "smc_regs.vh"

module smc_buf
(
    // clock and reset
    input  wire                   clk_sys_i,
    input  wire                   reset_i,
    // fill side
    input  wire                   in_valid_i,
    output wire                   in_ready_o,
    input  wire [`SMC_BUF_W-1:0]  in_data_i,
    // drain side
    output wire                   out_valid_o,
    input  wire                   out_ready_i,
    output wire [`SMC_BUF_W-1:0]  out_data_o
);

    reg  [`SMC_BUF_W-1:0] mem_r [0:1];
    reg                   wr_ptr_r;
    reg                   rd_ptr_r;
    reg  [1:0]            count_r;
    wire                  push;
    wire                  pop;

    assign in_ready_o  = (count_r != 2'd2);
    assign out_valid_o = (count_r != 2'd0);
    assign out_data_o  = mem_r[rd_ptr_r];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always @(posedge clk_sys_i)
    begin
        if (push)
        begin
            mem_r[wr_ptr_r] <= in_data_i;
        end
    end

    always @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            count_r  <= 2'd0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_r <= ~wr_ptr_r;
            end
            if (pop)
            begin
                rd_ptr_r <= ~rd_ptr_r;
            end
            if (push & ~pop)
            begin
                count_r <= count_r + 2'd1;
            end
            else if (pop & ~push)
            begin
                count_r <= count_r - 2'd1;
            end
        end
    end

endmodule

// ===== tb/smc_core_sva.sv
// assertion checker for the serial memory command logic
`timescale 1ns/100ps
`include "smc_regs.vh"

module smc_chk
(
    // clock and reset
    input wire               clk_sys_i,
    input wire               reset_i,
    // pins
    input wire               sel_n_i,
    input wire               pause_n_i,
    input wire               sdo_oe_n_o,
    // commit stream
    input wire               commit_valid_o,
    input wire               commit_ready_i,
    input wire [`SMC_AW-1:0] commit_addr_o,
    input wire [7:0]         commit_data_o,
    // observation
    input wire [7:0]         status_o,
    input wire               paused_o,
    input wire               overrun_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    property p_reset_idle;
        $fell(reset_i) |-> status_o == 8'h00 && sdo_oe_n_o
            && !commit_valid_o && !paused_o && !overrun_o;
    endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("state not idle after reset");

    property p_desel_float;
        sel_n_i [*5] |-> sdo_oe_n_o;
    endproperty
    a_desel_float: assert property (p_desel_float)
        else $error("output driven while deselected");

    property p_bit0_zero;
        status_o[0] == 1'b0;
    endproperty
    a_bit0_zero: assert property (p_bit0_zero)
        else $error("status bit 0 not zero");

    property p_pause_float;
        paused_o |-> sdo_oe_n_o;
    endproperty
    a_pause_float: assert property (p_pause_float)
        else $error("output driven while paused");

    property p_pause_end;
        pause_n_i [*8] |-> !paused_o;
    endproperty
    a_pause_end: assert property (p_pause_end)
        else $error("pause held after pin released");

    property p_desel_abort;
        sel_n_i [*5] |-> !paused_o;
    endproperty
    a_desel_abort: assert property (p_desel_abort)
        else $error("pause survives deselect");

    property p_head_holds;
        commit_valid_o && !commit_ready_i |=> commit_valid_o
            && $stable(commit_addr_o) && $stable(commit_data_o);
    endproperty
    a_head_holds: assert property (p_head_holds)
        else $error("stalled write word changed");

    property p_overrun_full;
        $rose(overrun_o) |-> commit_valid_o;
    endproperty
    a_overrun_full: assert property (p_overrun_full)
        else $error("overrun with empty buffer");

    property p_stat_latch;
        $changed(status_o[7:2]) |-> $past(status_o[1]);
    endproperty
    a_stat_latch: assert property (p_stat_latch)
        else $error("status changed without write latch");

    cover property ($rose(paused_o));
    cover property (commit_valid_o && commit_ready_i);
    cover property ($rose(overrun_o));
    cover property ($changed(status_o[7:2]));
endmodule

bind smc_core smc_chk smc_chk_inst
(
    .clk_sys_i      (clk_sys_i),
    .reset_i        (reset_i),
    .sel_n_i        (sel_n_i),
    .pause_n_i      (pause_n_i),
    .sdo_oe_n_o     (sdo_oe_n_o),
    .commit_valid_o (commit_valid_o),
    .commit_ready_i (commit_ready_i),
    .commit_addr_o  (commit_addr_o),
    .commit_data_o  (commit_data_o),
    .status_o       (status_o),
    .paused_o       (paused_o),
    .overrun_o      (overrun_o)
);

// ===== tb/smc_host.sv
// spi host model, mode 0, driving the memory's serial pins
`timescale 1ns/100ps

module smc_host
(
    // clock
    input  wire clk_sys_i,
    // serial pins
    output reg  sel_n_o,
    output reg  sclk_o,
    output reg  sdi_o,
    input  wire sdo_i,
    input  wire sdo_oe_n_i
);
    initial
    begin
        sel_n_o = 1'b1;
        sclk_o  = 1'b0;
        sdi_o   = 1'b0;
    end

    task start;
    begin
        @(posedge clk_sys_i);
        sel_n_o <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
    end
    endtask

    // released data line flips so a stale level is never seen
    task stop;
    begin
        @(posedge clk_sys_i);
        sel_n_o <= 1'b1;
        sdi_o   <= ~sdi_o;
        repeat (6) @(posedge clk_sys_i);
    end
    endtask

    task bit_io(input b, output r);
    begin
        sdi_o <= b;
        repeat (4) @(posedge clk_sys_i);
        // a floating output reads as unknown
        r = sdo_oe_n_i ? 1'bx : sdo_i;
        sclk_o <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        sclk_o <= 1'b0;
    end
    endtask

    task xfer(input [7:0] tx, output [7:0] rx);
        integer i;
    begin
        for (i = 7; i >= 0; i = i - 1)
            bit_io(tx[i], rx[i]);
    end
    endtask
endmodule

// ===== tb/test_spi_serial_memory_command_logic.sv
// self-checking bench for the serial memory command logic
`timescale 1ns/100ps
`include "smc_regs.vh"

module test_spi_serial_memory_command_logic;
    localparam [7:0] SETL = `SMC_OP_SET_LATCH;
    reg         clk_sys_i = 1'b0;
    reg         reset_i = 1'b1;
    reg         pause_n_i = 1'b1;
    reg         wr_guard_n_i = 1'b1;
    reg         commit_ready_i = 1'b1;
    wire        sel_n, sclk, sdi, sdo, sdo_oe_n, cvalid, paused, ovr;
    wire [12:0] caddr;
    wire [7:0]  cdata, status;
    reg  [7:0]  rx, exp [0:2];
    integer     n_mismatch = 0, checked = 0, g, k;

    always #20 clk_sys_i = ~clk_sys_i;

    smc_host smc_host_inst
    (
        .clk_sys_i  (clk_sys_i),
        .sel_n_o    (sel_n),
        .sclk_o     (sclk),
        .sdi_o      (sdi),
        .sdo_i      (sdo),
        .sdo_oe_n_i (sdo_oe_n)
    );

    smc_core smc_core_inst
    (
        .clk_sys_i      (clk_sys_i),
        .reset_i        (reset_i),
        .sel_n_i        (sel_n),
        .sclk_i         (sclk),
        .sdi_i          (sdi),
        .pause_n_i      (pause_n_i),
        .wr_guard_n_i   (wr_guard_n_i),
        .sdo_o          (sdo),
        .sdo_oe_n_o     (sdo_oe_n),
        .commit_valid_o (cvalid),
        .commit_ready_i (commit_ready_i),
        .commit_addr_o  (caddr),
        .commit_data_o  (cdata),
        .status_o       (status),
        .paused_o       (paused),
        .overrun_o      (ovr)
    );

    task test_done;
    begin
        $display("checks %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask

    task check(input string what, input [12:0] seen, input [12:0] want);
    begin
        checked = checked + 1;
        if (seen !== want)
        begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected %s: expected %h, seen %h", what, want, seen);
        end
    end
    endtask

    task wait_paused(input want);
        integer i;
    begin
        for (i = 0; i < 12 && paused !== want; i = i + 1)
            @(posedge clk_sys_i);
        check("paused", paused, want);
        if (paused !== want)
            test_done;
    end
    endtask

    task cmd(input [7:0] op);
    begin
        smc_host_inst.start;
        smc_host_inst.xfer(op, rx);
    end
    endtask

    task op_only(input [7:0] op);
    begin
        cmd(op);
        smc_host_inst.stop;
    end
    endtask

    task stat_wr(input en, input [7:0] v);
    begin
        if (en)
            op_only(`SMC_OP_SET_LATCH);
        cmd(`SMC_OP_STAT_WRITE);
        smc_host_inst.xfer(v, rx);
        smc_host_inst.stop;
    end
    endtask

    task mem_op(input [7:0] op, input [15:0] a, input [7:0] d);
    begin
        cmd(op);
        smc_host_inst.xfer(a[15:8], rx);
        smc_host_inst.xfer(a[7:0], rx);
        smc_host_inst.xfer(d, rx);
    end
    endtask

    task mem_wr(input en, input [15:0] a, input [7:0] d);
    begin
        if (en)
            op_only(`SMC_OP_SET_LATCH);
        mem_op(`SMC_OP_MEM_WRITE, a, d);
    end
    endtask

    function [15:0] adr(input integer i);
        adr = i == 0 ? 16'h0fff : i == 1 ? 16'h17ff : 16'h1800;
    endfunction

    initial
    begin
        repeat (20) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        check("oe_n", sdo_oe_n, 1'b1);
        check("status", status, 8'h00);
        smc_host_inst.start;
        for (k = 7; k > 0; k = k - 1)
            smc_host_inst.bit_io(SETL[k], rx[0]);
        smc_host_inst.stop;
        check("status", status, 8'h00);
        stat_wr(1'b0, 8'hfc);
        check("status", status, 8'h00);
        op_only(`SMC_OP_SET_LATCH);
        check("status", status, 8'h02);
        cmd(`SMC_OP_STAT_READ);
        smc_host_inst.xfer(8'hff, rx);
        check("sdo", rx, 8'h02);
        smc_host_inst.xfer(8'h00, rx);
        check("sdo", rx, 8'h02);
        smc_host_inst.stop;
        op_only(`SMC_OP_CLR_LATCH);
        check("status", status, 8'h00);
        stat_wr(1'b1, 8'hff);
        check("status", status, 8'hfc);
        // pin is settled well before the command and held through it
        wr_guard_n_i <= 1'b0;
        stat_wr(1'b1, 8'h00);
        check("status", status, 8'hfc);
        wr_guard_n_i <= 1'b1;
        stat_wr(1'b1, 8'h00);
        check("status", status, 8'h00);
        for (g = 0; g < 4; g = g + 1)
        begin
            if (g > 0)
                stat_wr(1'b1, g << 2);
            for (k = 0; k < 3; k = k + 1)
            begin
                mem_wr(1'b1, adr(k), 8'h20 + g);
                smc_host_inst.stop;
                if (g == 0 || g == 1 && adr(k) < `SMC_GUARD_QTR
                        || g == 2 && adr(k) < `SMC_GUARD_HALF)
                    exp[k] = 8'h20 + g;
            end
            for (k = 0; k < 3; k = k + 1)
            begin
                mem_op(`SMC_OP_MEM_READ, adr(k), 8'h00);
                smc_host_inst.stop;
                check("mem", rx, exp[k]);
            end
        end
        cmd(`SMC_OP_STAT_READ);
        pause_n_i <= 1'b0;
        wait_paused(1'b1);
        smc_host_inst.xfer(8'hff, rx);
        check("sdo", rx, 8'bx);
        pause_n_i <= 1'b1;
        wait_paused(1'b0);
        smc_host_inst.xfer(8'h00, rx);
        check("sdo", rx, 8'h0c);
        pause_n_i <= 1'b0;
        wait_paused(1'b1);
        smc_host_inst.stop;
        wait_paused(1'b0);
        pause_n_i <= 1'b1;
        cmd(`SMC_OP_STAT_READ);
        smc_host_inst.xfer(8'h00, rx);
        check("sdo", rx, 8'h0c);
        smc_host_inst.stop;
        stat_wr(1'b1, 8'h00);
        mem_wr(1'b0, adr(0), 8'h55);
        smc_host_inst.stop;
        mem_op(`SMC_OP_MEM_READ, adr(0), 8'h00);
        smc_host_inst.stop;
        check("mem", rx, exp[0]);
        mem_wr(1'b1, 16'hffff, 8'ha1);
        smc_host_inst.xfer(8'ha2, rx);
        smc_host_inst.stop;
        mem_op(`SMC_OP_MEM_READ, 16'hffff, 8'h00);
        check("mem", rx, 8'ha1);
        smc_host_inst.xfer(8'h00, rx);
        smc_host_inst.stop;
        check("mem", rx, 8'ha2);
        mem_op(`SMC_OP_MEM_READ, 16'he000, 8'h00);
        smc_host_inst.stop;
        check("mem", rx, 8'ha2);
        commit_ready_i <= 1'b0;
        mem_wr(1'b1, 16'h0100, 8'h31);
        smc_host_inst.xfer(8'h32, rx);
        smc_host_inst.xfer(8'h33, rx);
        repeat (4) @(posedge clk_sys_i);
        check("valid", cvalid, 1'b1);
        check("addr", caddr, 13'h0100);
        check("data", cdata, 8'h31);
        check("overrun", ovr, 1'b1);
        smc_host_inst.stop;
        check("overrun", ovr, 1'b0);
        commit_ready_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        check("valid", cvalid, 1'b0);
        mem_op(`SMC_OP_MEM_READ, 16'h0100, 8'h00);
        check("mem", rx, 8'h31);
        smc_host_inst.xfer(8'h00, rx);
        smc_host_inst.stop;
        check("mem", rx, 8'h32);
        cmd(8'hff);
        smc_host_inst.xfer(8'h00, rx);
        check("sdo", rx, 8'bx);
        smc_host_inst.stop;
        test_done;
    end
endmodule
